//--- tpsm_output_stage.sv
// three-phase steering output stage with time-base interrupt control, APB slave
// assumes time-base events are one-cycle pulses on core_clk; modulation signal is
// asynchronous and is synchronised here
// limitation: the modulation pin reaches the outputs three cycles late,
// the price of synchronising it before it gates the steered levels
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module tpsm_output_stage (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // time-base events
    input  wire logic        overflowEvent,
    input  wire logic        phaseMatch,
    input  wire logic        dutyMatch,
    input  wire logic        periodMatch,
    // modulation and other-mode drive
    input  wire logic        modulation_signal,
    input  wire logic [5:0]  otherModeLevel,
    // outputs
    output logic             out_a,
    output logic             out_b,
    output logic             out_c,
    output logic             out_d,
    output logic             out_e,
    output logic             out_f,
    output logic             irqRequest
);
    import tpsm_pkg::*;

    logic [7:0] time_base_irq_control;
    logic [5:0] steering_control_bits;
    logic [7:0] modCtrl;
    logic [7:0] next_irqCtrl;
    logic [5:0] next_steer;
    logic [7:0] next_modCtrl;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        next_pready;
    logic        modSync1;
    logic        modSync2;
    logic [5:0]  outLevel;
    logic [5:0]  next_outLevel;
    logic        next_irq;
    logic [5:0]  rawLevel;
    logic        wrEn;
    logic        rdEn;
    logic        mapped;
    logic [3:0]  events;
    logic [3:0]  enables;
    logic [3:0]  flags;
    logic        steerMode;
    logic        low_side_mod_enable;
    logic        high_side_mod_enable;

    tpsm_steer_decode u_decode (
        .steerBits (steering_control_bits),
        .rawLevel  (rawLevel)
    );

    assign steerMode            = (modCtrl[TPSM_MODE_LSB +: 4] == TPSM_MODE_STEER3);
    assign low_side_mod_enable  = modCtrl[TPSM_BIT_LS_MEN];
    assign high_side_mod_enable = modCtrl[TPSM_BIT_HS_MEN];
    assign events  = {overflowEvent, phaseMatch, dutyMatch, periodMatch};
    assign enables = time_base_irq_control[TPSM_BIT_OV_IE:TPSM_BIT_PR_IE];
    assign flags   = time_base_irq_control[TPSM_BIT_OV_IF:TPSM_BIT_PR_IF];

    // zero wait-state slave: access phase completes on its first cycle
    // unmapped addresses answer with pslverr; their writes are dropped
    assign wrEn   = psel && penable && pwrite;
    assign rdEn   = psel && !penable && !pwrite;
    assign mapped = (paddr == TPSM_OFS_IRQ_CTRL) || (paddr == TPSM_OFS_STEER)
                 || (paddr == TPSM_OFS_MOD_CTRL) || (paddr == TPSM_OFS_STATUS);

    // register writes; hardware flag set wins over a software clear
    always_comb begin
        next_irqCtrl = time_base_irq_control;
        next_steer   = steering_control_bits;
        next_modCtrl = modCtrl;
        if (wrEn && paddr == TPSM_OFS_IRQ_CTRL) begin
            next_irqCtrl = pwdata[7:0];
        end
        if (wrEn && paddr == TPSM_OFS_STEER) begin
            next_steer = pwdata[5:0];
        end
        if (wrEn && paddr == TPSM_OFS_MOD_CTRL) begin
            next_modCtrl = {pwdata[7:4], 2'b00, pwdata[1:0]};
        end
        // flags record every event; enables only gate the request
        next_irqCtrl[TPSM_BIT_OV_IF:TPSM_BIT_PR_IF] =
            next_irqCtrl[TPSM_BIT_OV_IF:TPSM_BIT_PR_IF] | events;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            time_base_irq_control <= TPSM_RST_IRQ_CTRL;
            steering_control_bits <= TPSM_RST_STEER;
            modCtrl               <= TPSM_RST_MOD_CTRL;
        end else begin
            time_base_irq_control <= next_irqCtrl;
            steering_control_bits <= next_steer;
            modCtrl               <= next_modCtrl;
        end
    end

    // read data registered in setup so it stands during the access phase
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        next_pready  = 1'b0;
        if (rdEn) begin
            unique case (paddr)
                TPSM_OFS_IRQ_CTRL: next_prdata = {24'h000000, time_base_irq_control};
                TPSM_OFS_STEER:    next_prdata = {26'h0000000, steering_control_bits};
                TPSM_OFS_MOD_CTRL: next_prdata = {24'h000000, modCtrl};
                TPSM_OFS_STATUS:   next_prdata = {26'h0000000, outLevel};
                default:           next_prdata = 32'h00000000;
            endcase
        end
        if (psel && !penable) begin
            next_pready  = 1'b1;
            next_pslverr = !mapped;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
            pready  <= next_pready;
        end
    end

    // modulation pin is asynchronous: two-stage synchroniser
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            modSync1 <= 1'b0;
            modSync2 <= 1'b0;
        end else begin
            modSync1 <= modulation_signal;
            modSync2 <= modSync1;
        end
    end

    // output gating; index order {f,e,d,c,b,a}, high side a,c,e at even bits
    always_comb begin
        next_outLevel = otherModeLevel;
        if (steerMode) begin
            for (int i = 0; i < 6; i++) begin
                if (i % 2 == 0) begin
                    next_outLevel[i] = rawLevel[i] & (modSync2 | !high_side_mod_enable);
                end else begin
                    next_outLevel[i] = rawLevel[i] & (modSync2 | !low_side_mod_enable);
                end
            end
        end
        next_irq = |(flags & enables);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            outLevel   <= 6'h00;
            irqRequest <= 1'b0;
        end else begin
            outLevel   <= next_outLevel;
            irqRequest <= next_irq;
        end
    end

    assign out_a = outLevel[0];
    assign out_b = outLevel[1];
    assign out_c = outLevel[2];
    assign out_d = outLevel[3];
    assign out_e = outLevel[4];
    assign out_f = outLevel[5];

    // assertions: one clock, all of them idle while reset is low

    // low side, b d f at the odd bits
    a_low_side_mod: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && low_side_mod_enable && !modSync2 |=> !out_b && !out_d && !out_f)
        else $error("low side not gated by modulation");

    a_low_side_follow: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && low_side_mod_enable && modSync2
        |=> {out_f, out_d, out_b} == $past({rawLevel[5], rawLevel[3], rawLevel[1]}))
        else $error("low side not following steering when modulation high");

    a_low_side_direct: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && !low_side_mod_enable |=> out_d == $past(rawLevel[3]))
        else $error("low side not driven directly");

    a_low_side_level: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && !low_side_mod_enable
        |=> out_b == $past(rawLevel[1]) && out_f == $past(rawLevel[5]))
        else $error("low side level differs from steering");

    // high side, a c e at the even bits
    a_high_side_gate: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && high_side_mod_enable && !modSync2 |=> !out_a && !out_c && !out_e)
        else $error("high side not gated by modulation");

    a_high_side_mod: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && high_side_mod_enable && modSync2 |=> out_a == $past(rawLevel[0]))
        else $error("high side not following steering when modulation high");

    a_high_side_direct: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && !high_side_mod_enable
        |=> {out_e, out_c, out_a} == $past({rawLevel[4], rawLevel[2], rawLevel[0]}))
        else $error("high side not driven directly");

    a_other_mode_pass: assert property (@(posedge core_clk) disable iff (!resetn)
        !steerMode |=> {out_f, out_e, out_d, out_c, out_b, out_a} == $past(otherModeLevel))
        else $error("enables affected output outside steering mode");

    // steering decode
    a_steer_priority: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && !low_side_mod_enable && !high_side_mod_enable
        && steering_control_bits[0] |=> out_a && out_d && !out_f)
        else $error("lowest steering bit did not take precedence");

    a_steer_none: assert property (@(posedge core_clk) disable iff (!resetn)
        steerMode && steering_control_bits == 6'h00 |=> {out_f, out_e, out_d, out_c, out_b, out_a} == 6'h00)
        else $error("outputs high with no steering bit set");

    // flags and request
    a_overflow_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
        overflowEvent |=> time_base_irq_control[TPSM_BIT_OV_IF])
        else $error("overflow flag not set");

    a_overflow_held: assert property (@(posedge core_clk) disable iff (!resetn)
        flags[3] && !(wrEn && paddr == TPSM_OFS_IRQ_CTRL) |=> flags[3])
        else $error("overflow flag lost without a software clear");

    a_phase_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        phaseMatch |=> time_base_irq_control[TPSM_BIT_PH_IF])
        else $error("phase flag not set");

    a_duty_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        dutyMatch |=> time_base_irq_control[TPSM_BIT_DC_IF])
        else $error("duty flag not set");

    a_period_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        periodMatch |=> time_base_irq_control[TPSM_BIT_PR_IF])
        else $error("period flag not set");

    a_irq_gated: assert property (@(posedge core_clk) disable iff (!resetn)
        (flags & enables) == 4'h0 |=> !irqRequest)
        else $error("interrupt raised by disabled flag");

    a_irq_raised: assert property (@(posedge core_clk) disable iff (!resetn)
        flags[3] && enables[3] |=> irqRequest)
        else $error("interrupt missing for enabled flag");

    a_irq_any: assert property (@(posedge core_clk) disable iff (!resetn)
        (flags & enables) != 4'h0 |=> irqRequest)
        else $error("interrupt missing for an enabled flag");

    // register bus, no wait states
    a_apb_ready_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    a_apb_unmapped: assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && !mapped |=> pready && pslverr)
        else $error("unmapped address answered without error");

    a_apb_mapped: assert property (@(posedge core_clk) disable iff (!resetn)
        psel && !penable && mapped |=> pready && !pslverr)
        else $error("mapped address answered with error");

    // main scenarios
    c_steer_mod: cover property (@(posedge core_clk) disable iff (!resetn)
        steerMode && high_side_mod_enable && out_a);
    c_irq: cover property (@(posedge core_clk) disable iff (!resetn) irqRequest);
    c_flag_clear: cover property (@(posedge core_clk) disable iff (!resetn)
        flags[2] ##1 !flags[2]);
    c_low_mod: cover property (@(posedge core_clk) disable iff (!resetn)
        steerMode && low_side_mod_enable && modSync2 && out_b);
    c_set_wins: cover property (@(posedge core_clk) disable iff (!resetn)
        overflowEvent && wrEn && paddr == TPSM_OFS_IRQ_CTRL
        && !pwdata[TPSM_BIT_OV_IF]);
endmodule : tpsm_output_stage
`default_nettype wire

//--- tpsm_pkg.sv
// package for the three-phase steering output stage and time-base interrupt control
// assumes a 25 MHz core clock and an APB register bus
package tpsm_pkg;
    // register byte addresses
    localparam logic [7:0] TPSM_OFS_IRQ_CTRL  = 8'h00;
    localparam logic [7:0] TPSM_OFS_STEER     = 8'h04;
    localparam logic [7:0] TPSM_OFS_MOD_CTRL  = 8'h08;
    localparam logic [7:0] TPSM_OFS_STATUS    = 8'h0c;
    // time_base_irq_control fields
    localparam int TPSM_BIT_OV_IE  = 7;
    localparam int TPSM_BIT_PH_IE  = 6;
    localparam int TPSM_BIT_DC_IE  = 5;
    localparam int TPSM_BIT_PR_IE  = 4;
    localparam int TPSM_BIT_OV_IF  = 3;
    localparam int TPSM_BIT_PH_IF  = 2;
    localparam int TPSM_BIT_DC_IF  = 1;
    localparam int TPSM_BIT_PR_IF  = 0;
    // modulation control fields: mode in [7:4], low-side enable, high-side enable
    localparam int TPSM_BIT_LS_MEN = 1;
    localparam int TPSM_BIT_HS_MEN = 0;
    localparam int TPSM_MODE_LSB   = 4;
    localparam logic [3:0] TPSM_MODE_STEER3 = 4'hc;
    // reset values
    localparam logic [7:0] TPSM_RST_IRQ_CTRL = 8'h00;
    localparam logic [5:0] TPSM_RST_STEER    = 6'h00;
    localparam logic [7:0] TPSM_RST_MOD_CTRL = 8'h00;
    // combinations driven high per steering bit {f,e,d,c,b,a}
    localparam logic [5:0] TPSM_COMBO0 = 6'h09; // a and d
    localparam logic [5:0] TPSM_COMBO1 = 6'h21; // a and f
    localparam logic [5:0] TPSM_COMBO2 = 6'h24; // c and f
    localparam logic [5:0] TPSM_COMBO3 = 6'h06; // c and b
    localparam logic [5:0] TPSM_COMBO4 = 6'h12; // e and b
    localparam logic [5:0] TPSM_COMBO5 = 6'h18; // e and d
endpackage : tpsm_pkg

//--- tpsm_steer_decode.sv
// decodes steering bits into the six raw output levels
// assumes steering bits come from a register on the same clock
`timescale 1ns/1ns
`default_nettype none
module tpsm_steer_decode (
    // steering
    input  wire logic [5:0] steerBits,
    // raw levels {f,e,d,c,b,a}
    output logic      [5:0] rawLevel
);
    import tpsm_pkg::*;
    always_comb begin
        // lowest set bit wins
        if (steerBits[0]) begin
            rawLevel = TPSM_COMBO0;
        end else if (steerBits[1]) begin
            rawLevel = TPSM_COMBO1;
        end else if (steerBits[2]) begin
            rawLevel = TPSM_COMBO2;
        end else if (steerBits[3]) begin
            rawLevel = TPSM_COMBO3;
        end else if (steerBits[4]) begin
            rawLevel = TPSM_COMBO4;
        end else if (steerBits[5]) begin
            rawLevel = TPSM_COMBO5;
        end else begin
            rawLevel = 6'h00;
        end
    end
endmodule : tpsm_steer_decode
`default_nettype wire

//--- tpsm_output_stage_tb.sv
// self-checking bench for the steering output stage and time-base interrupt control
// assumes zero-wait apb slave and registered outputs as in the package
`timescale 1ns/1ns
`default_nettype none
module tpsm_output_stage_tb;
    import tpsm_pkg::*;
    logic        core_clk = 0, resetn = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irqRequest, modSig = 0;
    logic        out_a, out_b, out_c, out_d, out_e, out_f;
    logic [3:0]  ev = 4'h0;
    logic [5:0]  other = 6'h00;
    logic [31:0] rd;
    logic        err;
    int          numErrors = 0, samplesChecked = 0, cycles = 0;
    logic [5:0]  combo [6] = '{TPSM_COMBO0, TPSM_COMBO1, TPSM_COMBO2,
                               TPSM_COMBO3, TPSM_COMBO4, TPSM_COMBO5};
    wire  [5:0]  outs = {out_f, out_e, out_d, out_c, out_b, out_a};

    always #20 core_clk = ~core_clk;

    tpsm_output_stage uut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .overflowEvent(ev[3]),
        .phaseMatch(ev[2]), .dutyMatch(ev[1]), .periodMatch(ev[0]),
        .modulation_signal(modSig), .otherModeLevel(other), .out_a(out_a),
        .out_b(out_b), .out_c(out_c), .out_d(out_d), .out_e(out_e), .out_f(out_f),
        .irqRequest(irqRequest));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // entered just after a rising edge; waits for pready with no limit of its own,
    // releases the bus and lets one edge pass so the next call never reassigns psel
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_cyc

    task automatic test_reset_values;
        apb(0, TPSM_OFS_IRQ_CTRL, 0);
        chk("irq ctrl reset", rd, 32'h0);
        chk("mapped read no error", err, 1'b0);
        apb(0, TPSM_OFS_MOD_CTRL, 0);
        chk("mode ctrl reset", rd, 32'h0);
        chk("outputs after reset", outs, 6'h00);
        chk("irq after reset", irqRequest, 1'b0);
    endtask : test_reset_values

    task automatic test_steer_direct;
        // pass-through levels must not leak into steering mode
        other <= 6'h1e;
        apb(1, TPSM_OFS_MOD_CTRL, 32'hc0);
        for (int i = 0; i < 6; i++) begin
            apb(1, TPSM_OFS_STEER, 32'h1 << i);
            wait_cyc(2);
            chk("steer combo", outs, combo[i]);
        end
        apb(1, TPSM_OFS_STEER, 32'h3c);
        wait_cyc(2);
        chk("steer lowest wins", outs, combo[2]);
        apb(0, TPSM_OFS_STATUS, 0);
        chk("status levels", rd, {26'h0, combo[2]});
    endtask : test_steer_direct

    // low side is b,d,f (6'h2a); high side is a,c,e (6'h15)
    task automatic test_modulation;
        logic [5:0] expv;
        apb(1, TPSM_OFS_STEER, 32'h02);
        for (int en = 0; en < 4; en++) begin
            apb(1, TPSM_OFS_MOD_CTRL, 32'hc0 | en);
            modSig <= 1'b0;
            wait_cyc(5);
            expv = combo[1] & ~((en[0] ? 6'h15 : 6'h00) | (en[1] ? 6'h2a : 6'h00));
            chk("mod pin low", outs, expv);
            modSig <= 1'b1;
            wait_cyc(5);
            chk("mod pin high", outs, combo[1]);
        end
        apb(1, TPSM_OFS_STEER, 32'h00);
        wait_cyc(2);
        chk("steered low stays low", outs, 6'h00);
    endtask : test_modulation

    task automatic test_other_mode;
        apb(1, TPSM_OFS_STEER, 32'h01);
        apb(1, TPSM_OFS_MOD_CTRL, 32'h0f);
        other  <= 6'h2d;
        modSig <= 1'b0;
        wait_cyc(5);
        chk("other mode levels", outs, 6'h2d);
        apb(0, TPSM_OFS_MOD_CTRL, 0);
        chk("mode ctrl spare bits", rd, 32'h03);
        apb(1, 8'h10, 32'hff);
        chk("unmapped error", err, 1'b1);
        apb(0, 8'h10, 0);
        chk("unmapped read", rd, 32'h0);
        chk("unmapped read error", err, 1'b1);
    endtask : test_other_mode

    task automatic test_flags;
        logic [7:0] f;
        for (int i = 0; i < 4; i++) begin
            f = 8'h1 << i;
            apb(1, TPSM_OFS_IRQ_CTRL, 32'h0);
            ev <= f[3:0];
            @(posedge core_clk);
            ev <= 4'h0;
            wait_cyc(4);
            apb(0, TPSM_OFS_IRQ_CTRL, 0);
            chk("flag set", rd, {24'h0, f});
            chk("irq blocked", irqRequest, 1'b0);
            apb(1, TPSM_OFS_IRQ_CTRL, {24'h0, f << 4 | f});
            wait_cyc(3);
            chk("irq raised", irqRequest, 1'b1);
            apb(1, TPSM_OFS_IRQ_CTRL, {24'h0, f << 4});
            wait_cyc(3);
            apb(0, TPSM_OFS_IRQ_CTRL, 0);
            chk("flag cleared", rd, {24'h0, f << 4});
            chk("irq dropped", irqRequest, 1'b0);
        end
        // overflow event on the very edge of a clearing write: the set wins
        fork
            apb(1, TPSM_OFS_IRQ_CTRL, 32'h0);
            begin
                wait_cyc(1);
                ev <= 4'h8;
                wait_cyc(1);
                ev <= 4'h0;
            end
        join
        apb(0, TPSM_OFS_IRQ_CTRL, 0);
        chk("set beats clear", rd, 32'h08);
    endtask : test_flags

    // reset in mid-run: every register and output returns to zero
    task automatic test_mid_reset;
        apb(1, TPSM_OFS_MOD_CTRL, 32'hc0);
        apb(1, TPSM_OFS_STEER, 32'h04);
        wait_cyc(2);
        chk("steered before reset", outs, combo[2]);
        resetn <= 1'b0;
        wait_cyc(2);
        chk("outputs in reset", outs, 6'h00);
        resetn <= 1'b1;
        @(posedge core_clk);
        apb(0, TPSM_OFS_MOD_CTRL, 0);
        chk("mode ctrl after reset", rd, 32'h0);
        apb(0, TPSM_OFS_STEER, 0);
        chk("steer after reset", rd, 32'h0);
        apb(0, TPSM_OFS_IRQ_CTRL, 0);
        chk("irq ctrl after reset", rd, 32'h0);
    endtask : test_mid_reset

    task automatic giveVerdict;
        $display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : giveVerdict

    // the whole run needs well under 1000 cycles; the ceiling leaves ample room
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            giveVerdict();
        end
    end

    initial begin
        wait_cyc(12);
        resetn <= 1'b1;
        @(posedge core_clk);
        test_reset_values();
        test_steer_direct();
        test_modulation();
        test_other_mode();
        test_flags();
        test_mid_reset();
        giveVerdict();
    end
endmodule : tpsm_output_stage_tb
`default_nettype wire
